//--- core/buck_mode_ramp_protection_ctrl.sv
// Digital control of a step-down converter: reference ramping, mode, sync,
// spread spectrum, discharge and supply lockout handling.
// Assumes all inputs synchronous to clk; comparator inputs already synchronised.
`timescale 1ns/1ps

//////////////////////////////////////////////////////////////////////////////
module buck_mode_ramp_protection_ctrl
  import ramp_ctrl_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        enable_pin,
  input  wire logic        mode_sync_pin,
  input  wire logic        sync_clock_valid,
  input  wire logic        secondary_device,
  input  wire logic        thermal_shutdown,
  input  wire logic        supply_low_lockout,
  input  wire logic        supply_high_lockout,
  input  wire logic        supply_above_discharge_min,
  input  wire logic [7:0]  load_current,
  input  wire logic        cfg_write,
  input  wire logic [7:0]  voltage_setpoint_code,
  input  wire logic        setpoint_write,
  input  wire logic [1:0]  voltage_range_field,
  input  wire logic [1:0]  slew_rate_select,
  input  wire logic        load_droop_enable,
  input  wire logic        forced_pwm_bit,
  input  wire logic        spread_spectrum_enable,
  input  wire logic        output_discharge_enable,
  input  wire logic        switching_enable_bit,
  output logic [15:0]      vref_out,
  output logic [15:0]      target_out,
  output logic             switching_on,
  output logic             soft_start_pulse,
  output logic             forced_pwm_active,
  output logic             sync_to_external,
  output logic             spread_active,
  output logic signed [5:0] spread_offset_pct,
  output logic             discharge_on,
  output logic             ramp_busy,
  output logic [1:0]       active_range,
  output logic [1:0]       active_slew
);

  ////////////////////////////////////////////////////////////////////////////
  // State.

  typedef struct packed {
    conv_state_t st;
    logic [7:0]  set_code;
    logic [1:0]  range_pend;
    logic [1:0]  range;
    logic [1:0]  slew;
    logic        droop;
    logic        fpwm;
    logic        ssc_en;
    logic        dis_en;
    logic        sw_en;
    logic        enabled_once;
    logic        high_lock_seen;
    logic        cfg_pend;
    logic [7:0]  pend_code;
    logic        pend_set;
    logic [1:0]  pend_slew;
    logic        pend_droop;
    logic        pend_fpwm;
    logic        pend_ssc;
    logic        pend_dis;
    logic        pend_sw;
    logic [7:0]  slew_cnt;
    logic [15:0] vref;
    logic [15:0] target;
    logic        sw_on;
    logic        ss_pulse;
    logic        fpwm_act;
    logic        sync_ext;
    logic        ssc_act;
    logic signed [5:0] ssc_off;
    logic        dis_on;
    logic        busy;
  } ctrl_state_t;

  ctrl_state_t s_reg;
  ctrl_state_t s_next;
  logic signed [5:0] spread_pct;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers.

  // Setpoint code in 0.25 mV units for the active range.
  function automatic logic [15:0] code_to_vref(input logic [1:0] rng, input logic [7:0] code);
    logic [15:0] mult;
    mult = 16'h0014;
    unique case (rng)
      RANGE_FINE: mult = 16'h0005;
      RANGE_MID:  mult = 16'h000A;
      default:    mult = 16'h0014;
    endcase
    code_to_vref = VREF_BASE + 16'({8'h00, code} * mult);
  endfunction

  function automatic logic [7:0] slew_cycles(input logic [1:0] code);
    logic [7:0] c;
    c = SLEW2_CYC;
    unique case (code)
      2'h0: c = SLEW0_CYC;
      2'h1: c = SLEW1_CYC;
      2'h2: c = SLEW2_CYC;
      2'h3: c = SLEW3_CYC;
    endcase
    slew_cycles = c;
  endfunction

  // Droop shift is absolute: plus half span at no load, minus half at full.
  function automatic logic [15:0] droop_apply(input logic [15:0] v, input logic [7:0] iload);
    logic [15:0] shift;
    shift = 16'((DROOP_SPAN * {8'h00, iload}) >> 8);
    droop_apply = v + (DROOP_SPAN >> 1) - shift;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic.

  always_comb begin
    logic run_req;
    logic locked;
    logic [15:0] goal;
    s_next = s_reg;
    s_next.ss_pulse = 1'b0;
    run_req = 1'b0;
    locked  = 1'b0;
    goal    = 16'h0000;

    // Configuration captured into a pending copy; applied when no ramp runs, the range only with the next setpoint.
    if (cfg_write) begin
      s_next.cfg_pend   = 1'b1;
      s_next.pend_slew  = slew_rate_select;
      s_next.pend_droop = load_droop_enable;
      s_next.pend_fpwm  = forced_pwm_bit;
      s_next.pend_ssc   = spread_spectrum_enable;
      s_next.pend_dis   = output_discharge_enable;
      s_next.pend_sw    = switching_enable_bit;
      s_next.range_pend = voltage_range_field;
    end
    if (setpoint_write) begin
      s_next.pend_set  = 1'b1;
      s_next.pend_code = voltage_setpoint_code;
    end
    if (s_reg.st != ST_RAMP) begin
      if (s_reg.cfg_pend) begin
        s_next.cfg_pend = cfg_write;
        s_next.slew     = s_reg.pend_slew;
        s_next.droop    = s_reg.pend_droop;
        s_next.fpwm     = s_reg.pend_fpwm;
        s_next.ssc_en   = s_reg.pend_ssc;
        s_next.dis_en   = s_reg.pend_dis;
        s_next.sw_en    = s_reg.pend_sw;
      end
      if (s_reg.pend_set) begin
        s_next.pend_set = setpoint_write;
        s_next.set_code = s_reg.pend_code;
        s_next.range    = s_reg.range_pend;
      end
    end

    // Lockout and restart handling.
    if (supply_high_lockout) begin
      s_next.high_lock_seen = 1'b1;
    end
    locked  = supply_low_lockout | supply_high_lockout | thermal_shutdown;
    run_req = enable_pin & s_reg.sw_en & !locked;

    goal = code_to_vref(s_reg.range, s_reg.set_code);
    if (s_reg.droop) begin
      goal = droop_apply(goal, load_current);
    end
    s_next.target = goal;

    unique case (s_reg.st)
      ST_OFF: begin
        s_next.vref = VREF_BASE;
        if (run_req) begin
          s_next.st           = ST_RAMP;
          s_next.ss_pulse     = 1'b1;
          s_next.enabled_once = 1'b1;
          s_next.slew_cnt     = 8'h00;
        end else if (locked) begin
          s_next.st = ST_LOCKOUT;
        end
      end
      ST_RUN: begin
        if (!run_req) begin
          s_next.st = locked ? ST_LOCKOUT : ST_OFF;
        end else if (s_reg.vref != goal) begin
          s_next.st       = ST_RAMP;
          s_next.slew_cnt = 8'h00;
        end
      end
      ST_RAMP: begin
        if (!run_req) begin
          s_next.st = locked ? ST_LOCKOUT : ST_OFF;
        end else if (s_reg.vref == goal) begin
          s_next.st = ST_RUN;
        end else if (s_reg.slew_cnt >= slew_cycles(s_reg.slew) - 8'h01) begin
          s_next.slew_cnt = 8'h00;
          s_next.vref = (goal > s_reg.vref) ? s_reg.vref + 16'h0001 : s_reg.vref - 16'h0001;
        end else begin
          s_next.slew_cnt = s_reg.slew_cnt + 8'h01;
        end
      end
      ST_LOCKOUT: begin
        s_next.vref = VREF_BASE;
        if (!locked) begin
          // Fresh soft start once the low, high and thermal lockouts have all released.
          s_next.high_lock_seen = 1'b0;
          s_next.st = ST_OFF;
        end
      end
    endcase

    s_next.sw_on    = (s_next.st == ST_RUN) || (s_next.st == ST_RAMP);
    s_next.busy     = (s_next.st == ST_RAMP);
    s_next.sync_ext = sync_clock_valid | secondary_device;
    s_next.fpwm_act = mode_sync_pin | s_reg.fpwm | s_next.sync_ext;
    s_next.ssc_act  = s_reg.ssc_en & s_next.fpwm_act & !s_next.sync_ext;
    s_next.ssc_off  = s_reg.ssc_act ? spread_pct : 6'sd0;
    // Discharge only while off, after the first enable, with supply present.
    s_next.dis_on = s_reg.dis_en & s_reg.enabled_once & supply_above_discharge_min
                    & (!enable_pin | !s_reg.sw_en | locked);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers.

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_reg        <= '0;
      s_reg.st     <= ST_OFF;
      s_reg.set_code   <= SETPOINT_RESET;
      s_reg.range      <= RANGE_RESET;
      s_reg.range_pend <= RANGE_RESET;
      s_reg.slew       <= SLEW_RESET;
      s_reg.pend_slew  <= SLEW_RESET;
      s_reg.dis_en     <= DISCHARGE_RESET;
      s_reg.pend_dis   <= DISCHARGE_RESET;
      s_reg.sw_en      <= 1'b1;
      s_reg.pend_sw    <= 1'b1;
      s_reg.vref       <= VREF_BASE;
      s_reg.target     <= VREF_BASE;
    end else begin
      s_reg <= s_next;
    end
  end

  spread_gen u_spread (
    .clk        (clk),
    .rst_n      (rst_n),
    .enable     (s_reg.ssc_act),
    .offset_pct (spread_pct)
  );

  assign vref_out          = s_reg.vref;
  assign target_out        = s_reg.target;
  assign switching_on      = s_reg.sw_on;
  assign soft_start_pulse  = s_reg.ss_pulse;
  assign forced_pwm_active = s_reg.fpwm_act;
  assign sync_to_external  = s_reg.sync_ext;
  assign spread_active     = s_reg.ssc_act;
  assign spread_offset_pct = s_reg.ssc_off;
  assign discharge_on      = s_reg.dis_on;
  assign ramp_busy         = s_reg.busy;
  assign active_range      = s_reg.range;
  assign active_slew       = s_reg.slew;

endmodule

//--- inc/ramp_ctrl_pkg.sv
// Constants shared by the converter control logic.
// Assumes a 50 MHz system clock; voltages are kept in units of 0.25 mV.
package ramp_ctrl_pkg;

  localparam int          CLK_MHZ          = 50;
  // Reference step resolution is 0.25 mV; base voltage 0.4 V.
  localparam logic [15:0] VREF_BASE        = 16'h0640;
  localparam logic [1:0]  RANGE_FINE       = 2'h0;
  localparam logic [1:0]  RANGE_MID        = 2'h1;
  localparam logic [1:0]  RANGE_RESET      = 2'h2;
  localparam logic [1:0]  SLEW_RESET       = 2'h2;
  localparam logic        DISCHARGE_RESET  = 1'h1;
  localparam logic [7:0]  SETPOINT_RESET   = 8'h50;
  // Ramp step is 0.25 mV; nanoseconds per step for each slew code.
  localparam int          SLEW0_NS_PER_STEP = 25;
  localparam int          SLEW1_NS_PER_STEP = 50;
  localparam int          SLEW2_NS_PER_STEP = 200;
  localparam int          SLEW3_NS_PER_STEP = 500;
  localparam logic [7:0]  SLEW0_CYC = 8'((SLEW0_NS_PER_STEP * CLK_MHZ + 999) / 1000);
  localparam logic [7:0]  SLEW1_CYC = 8'((SLEW1_NS_PER_STEP * CLK_MHZ + 999) / 1000);
  localparam logic [7:0]  SLEW2_CYC = 8'((SLEW2_NS_PER_STEP * CLK_MHZ + 999) / 1000);
  localparam logic [7:0]  SLEW3_CYC = 8'((SLEW3_NS_PER_STEP * CLK_MHZ + 999) / 1000);
  // Spread spectrum: plus/minus ten percent in steps of one percent.
  localparam logic [4:0]  SPREAD_PERCENT   = 5'h0A;
  localparam logic [7:0]  SPREAD_STEP_CYC  = 8'h32;
  // Droop offset: full-scale 16 mV of absolute shift, centred at half load.
  localparam logic [15:0] DROOP_SPAN       = 16'h0040;

  typedef enum logic [1:0] {
    ST_OFF     = 2'h0,
    ST_RUN     = 2'h1,
    ST_RAMP    = 2'h3,
    ST_LOCKOUT = 2'h2
  } conv_state_t;

endpackage

//--- core/spread_gen.sv
// Triangular spread-spectrum offset generator.
// Assumes a single clock; enable gates the sweep and parks it at zero.
`timescale 1ns/1ps
module spread_gen
  import ramp_ctrl_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       enable,
  output logic signed [5:0] offset_pct
);

  typedef struct packed {
    logic [7:0]        div;
    logic signed [5:0] pos;
    logic              down;
  } spread_state_t;

  spread_state_t s_reg;
  spread_state_t s_next;

  always_comb begin
    s_next = s_reg;
    if (!enable) begin
      s_next = '0;
    end else if (s_reg.div == SPREAD_STEP_CYC - 8'h01) begin
      s_next.div = 8'h00;
      // Triangle sweep between plus and minus the spread limit.
      if (s_reg.down) begin
        if (s_reg.pos == -$signed({1'b0, SPREAD_PERCENT})) begin
          s_next.down = 1'b0;
          s_next.pos  = s_reg.pos + 6'sd1;
        end else begin
          s_next.pos = s_reg.pos - 6'sd1;
        end
      end else begin
        if (s_reg.pos == $signed({1'b0, SPREAD_PERCENT})) begin
          s_next.down = 1'b1;
          s_next.pos  = s_reg.pos - 6'sd1;
        end else begin
          s_next.pos = s_reg.pos + 6'sd1;
        end
      end
    end else begin
      s_next.div = s_reg.div + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign offset_pct = s_reg.pos;

endmodule

//--- verif/buck_ctrl_properties.sv
// Concurrent checks on the ports of the converter control block.
// Assumes one clock domain with a synchronous active-low reset.
`timescale 1ns/1ps
module buck_ctrl_properties
  import ramp_ctrl_pkg::*;
(
  input wire logic              clk,
  input wire logic              rst_n,
  input wire logic              enable_pin,
  input wire logic              mode_sync_pin,
  input wire logic              sync_clock_valid,
  input wire logic              thermal_shutdown,
  input wire logic              supply_low_lockout,
  input wire logic              supply_high_lockout,
  input wire logic              supply_above_discharge_min,
  input wire logic [15:0]       vref_out,
  input wire logic              switching_on,
  input wire logic              soft_start_pulse,
  input wire logic              forced_pwm_active,
  input wire logic              sync_to_external,
  input wire logic              spread_active,
  input wire logic signed [5:0] spread_offset_pct,
  input wire logic              discharge_on,
  input wire logic              ramp_busy,
  input wire logic [1:0]        active_range,
  input wire logic [1:0]        active_slew
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Remembers whether the converter has been enabled since reset.
  logic enabled_reg;
  logic enabled_next;
  always_comb enabled_next = enabled_reg | enable_pin;
  always_ff @(posedge clk) begin
    enabled_reg <= rst_n ? enabled_next : 1'b0;
  end

  sequence ramping2;
    ramp_busy ##1 ramp_busy;
  endsequence
  sequence high_released;
    supply_high_lockout ##1 (!supply_high_lockout && !supply_low_lockout && !thermal_shutdown && enable_pin) [*2];
  endsequence

  ramp_hold_a: assert property (
    ramping2 |-> $stable(active_slew) && $stable(active_range)) else $error("setting moved in ramp");
  vref_step_a: assert property (
    ramping2 |-> vref_out - $past(vref_out) inside {16'h0000, 16'h0001, 16'hFFFF}) else $error("vref jumped");
  slew_gap_a: assert property (
    ramping2 ##0 $changed(vref_out) |=> $stable(vref_out)) else $error("vref stepped too fast");
  fpwm_or_a: assert property (
    switching_on && (mode_sync_pin || sync_clock_valid) |=> forced_pwm_active) else $error("forced pwm missing");
  sync_force_a: assert property (
    sync_clock_valid |=> sync_to_external && forced_pwm_active) else $error("sync not taken");
  spread_gate_a: assert property (
    sync_clock_valid [*2] |=> !spread_active) else $error("spread while synced");
  spread_span_a: assert property (
    spread_offset_pct <= 6'sh0A && spread_offset_pct >= -6'sh0A) else $error("spread beyond ten");
  lockout_stop_a: assert property (
    supply_low_lockout || supply_high_lockout |=> !switching_on) else $error("switching in lockout");
  discharge_idle_a: assert property (
    discharge_on |-> !switching_on) else $error("discharge while switching");
  first_enable_a: assert property (
    !enabled_reg |-> !discharge_on) else $error("discharge before enable");
  supply_floor_a: assert property (
    !supply_above_discharge_min |=> !discharge_on) else $error("discharge on low supply");
  restart_a: assert property (
    high_released |-> ##[0:8] soft_start_pulse) else $error("no restart after lockout");
endmodule

bind buck_mode_ramp_protection_ctrl buck_ctrl_properties props_i (
  .clk, .rst_n, .enable_pin, .mode_sync_pin, .sync_clock_valid, .thermal_shutdown, .supply_low_lockout,
  .supply_high_lockout, .supply_above_discharge_min, .vref_out, .switching_on, .soft_start_pulse,
  .forced_pwm_active, .sync_to_external, .spread_active, .spread_offset_pct, .discharge_on, .ramp_busy,
  .active_range, .active_slew
);

//--- verif/sync_source.sv
// External clock source standing at the mode/sync pin.
// Assumes run and level change just after a rising clock edge.
`timescale 1ns/1ps
module sync_source
  import ramp_ctrl_pkg::*;
(
  input  wire logic clk,
  input  wire logic run,
  input  wire logic level,
  output logic      mode_sync_pin,
  output logic      sync_clock_valid
);
  logic [1:0] div_reg;
  logic [2:0] age_reg;
  // The pin carries a clock while running and the static mode level otherwise.
  assign mode_sync_pin = run ? div_reg[1] : level;
  // Lock is reported only after several clock periods have been seen.
  assign sync_clock_valid = run && age_reg == 3'h7;
  always_ff @(posedge clk) begin
    div_reg <= run ? div_reg + 2'h1 : 2'h0;
    age_reg <= !run ? 3'h0 : (age_reg == 3'h7 ? age_reg : age_reg + 3'h1);
  end
endmodule

//--- verif/tb.sv
// Self-checking bench for the converter control block.
// Assumes the sync source model and the bound checker are compiled before it.
`timescale 1ns/1ps
module tb
  import ramp_ctrl_pkg::*;
();
  logic        clk, rst_n, enable_pin, sync_run, sync_level, secondary_device, mode_sync_pin, sync_clock_valid;
  logic        thermal_shutdown, supply_low_lockout, supply_high_lockout, supply_above_discharge_min;
  logic        cfg_write, setpoint_write, load_droop_enable, forced_pwm_bit, spread_spectrum_enable;
  logic        output_discharge_enable, switching_enable_bit, switching_on, soft_start_pulse;
  logic        forced_pwm_active, sync_to_external, spread_active, discharge_on, ramp_busy;
  logic [7:0]  load_current, voltage_setpoint_code;
  logic [1:0]  voltage_range_field, slew_rate_select, active_range, active_slew;
  logic [15:0] vref_out, target_out, nom;
  logic signed [5:0] spread_offset_pct;
  int          mismatches, n_compared, n, k;
  int          ns [4] = '{25, 50, 200, 500};
  logic [15:0] stp [4] = '{16'h0005, 16'h000A, 16'h0014, 16'h0014};
  // Rows: pin level, sync run, fpwm, spread, secondary, high, low, thermal, enable, supply | expected flags.
  logic [14:0] rows [10] = '{15'h0862, 15'h4876, 15'h1876, 15'h287A, 15'h0C7A,
                             15'h0261, 15'h0161, 15'h00E1, 15'h0021, 15'h0000};

  sync_source sync_source_i (.clk, .run(sync_run), .level(sync_level), .mode_sync_pin, .sync_clock_valid);
  buck_mode_ramp_protection_ctrl buck_mode_ramp_protection_ctrl_i (
    .clk, .rst_n, .enable_pin, .mode_sync_pin, .sync_clock_valid, .secondary_device, .thermal_shutdown,
    .supply_low_lockout, .supply_high_lockout, .supply_above_discharge_min, .load_current, .cfg_write,
    .voltage_setpoint_code, .setpoint_write, .voltage_range_field, .slew_rate_select, .load_droop_enable,
    .forced_pwm_bit, .spread_spectrum_enable, .output_discharge_enable, .switching_enable_bit, .vref_out,
    .target_out, .switching_on, .soft_start_pulse, .forced_pwm_active, .sync_to_external, .spread_active,
    .spread_offset_pct, .discharge_on, .ramp_busy, .active_range, .active_slew);

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////
  task step(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask
  task chk(input string nm, input logic [15:0] e, input logic [15:0] s);
    n_compared++;
    if (s !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask
  task cfg();
    cfg_write = 1'b1;
    step(1);
    cfg_write = 1'b0;
  endtask
  task setp(input logic [7:0] c);
    voltage_setpoint_code = c;
    setpoint_write = 1'b1;
    step(1);
    setpoint_write = 1'b0;
  endtask
  task apply(input logic [9:0] v);
    {sync_level, sync_run, forced_pwm_bit, spread_spectrum_enable, secondary_device, supply_high_lockout,
     supply_low_lockout, thermal_shutdown, enable_pin, supply_above_discharge_min} = v;
  endtask
  // Waits for the ramp to finish under a bound; a hang counts as a mismatch.
  task settle();
    k = 0;
    step(8);
    while (ramp_busy !== 1'b0 && k < 6000) begin
      step(1);
      k++;
    end
    chk("settle", 16'h0000, 16'(k == 6000));
    step(2);
  endtask
  task close_out();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    repeat (90000) @(posedge clk);
    mismatches++;
    close_out();
  end

  initial begin
    {rst_n, cfg_write, setpoint_write, load_droop_enable} = 4'h0;
    apply(10'h001);
    {output_discharge_enable, switching_enable_bit, load_current} = {2'h3, 8'h80};
    {voltage_range_field, slew_rate_select, voltage_setpoint_code} = {2'h2, 2'h2, 8'h50};
    mismatches = 0;
    n_compared = 0;
    repeat (16) @(posedge clk);
    #1 rst_n = 1'b1;
    step(1);
    chk("reset", {VREF_BASE[11:0], 4'hA}, {vref_out[11:0], active_range, active_slew});
    chk("reset_flags", 16'h0000, 16'({switching_on, discharge_on, ramp_busy}));
    apply(10'h003);
    step(3);
    apply(10'h001);
    step(4);
    chk("default_discharge", 16'h0001, 16'(discharge_on));
    {slew_rate_select, voltage_range_field} = 4'h0;
    cfg();
    step(3);
    chk("range_pending", 16'h0002, 16'(active_range));
    setp(8'h10);
    step(3);
    chk("range_taken", 16'h0000, 16'(active_range));
    apply(10'h003);
    step(1);
    chk("soft_start", 16'h0001, 16'(soft_start_pulse));
    step(1);
    chk("soft_start_end", 16'h0000, 16'(soft_start_pulse));
    settle();
    chk("startup_vref", 16'h0690, vref_out);
    $display("test startup done");
    for (int r = 0; r < 4; r++) begin
      voltage_range_field = 2'(r);
      cfg();
      setp(8'h20);
      settle();
      chk("target", VREF_BASE + 16'h0020 * stp[r], target_out);
      chk("vref", VREF_BASE + 16'h0020 * stp[r], vref_out);
    end
    for (int s = 0; s < 4; s++) begin
      slew_rate_select = 2'(s);
      cfg();
      step(3);
      setp(8'(8'h22 + 2 * s));
      {k, n, nom} = {32'h0, 32'h0, vref_out};
      while (vref_out === nom && k < 100) begin
        step(1);
        k++;
      end
      nom = vref_out;
      while (vref_out === nom && n < 100) begin
        step(1);
        n++;
      end
      chk("slew_cycles", 16'((ns[s] + 19) / 20), 16'(n));
      settle();
    end
    slew_rate_select = 2'h3;
    cfg();
    step(3);
    setp(8'h2C);
    step(20);
    slew_rate_select = 2'h0;
    cfg();
    step(5);
    chk("slew_held", 16'h0003, 16'(active_slew));
    settle();
    chk("slew_applied", 16'h0000, 16'(active_slew));
    $display("test ramp done");
    apply(10'h001);
    load_droop_enable = 1'b1;
    load_current = 8'h00;
    cfg();
    apply(10'h003);
    settle();
    nom = VREF_BASE + 16'h002C * 16'h0014;
    chk("droop_light", 16'h0001, 16'(target_out > nom));
    load_current = 8'hFF;
    step(5);
    chk("droop_heavy", 16'h0001, 16'(target_out < nom));
    apply(10'h001);
    load_droop_enable = 1'b0;
    cfg();
    apply(10'h003);
    settle();
    $display("test droop done");
    for (int i = 0; i < 10; i++) begin
      apply(rows[i][14:5]);
      cfg();
      step(12);
      chk("flags", 16'(rows[i][4:0]), 16'({forced_pwm_active, sync_to_external, spread_active, switching_on,
          discharge_on}));
      apply(10'h003);
      cfg();
      settle();
    end
    $display("test modes done");
    // The sweep moves one percent per 50 cycles, so any 50-cycle span holds one step.
    apply(10'h0C3);
    cfg();
    step(12);
    nom = 16'(spread_offset_pct);
    step(50);
    chk("spread_step", 16'h0001, 16'(spread_offset_pct) - nom);
    apply(10'h003);
    cfg();
    settle();
    $display("test spread done");
    close_out();
  end
endmodule
